// ---- rtl/mdv_top.v ----
// Contract
// - Unsigned 16x16 multiply, 32/16 and 16/16 divide.
// - Start only when byte 5 ends valid order.
// - Order tracked across unrelated bus traffic.
// - Bytes 0..5 ascending selects 32/16 division.
// - Bytes 0,1,4,5 selects 16/16 division.
// - Bytes 0,4,1,5 selects 16x16 multiplication.
// - Latency 17, 9 and 11 clock periods.
// - Data access while busy sets error bit 7.
// - Status read after completion clears error flag.
// - Overflow on product above FFFF or zero divisor.
// - Overflow flag rewritten on every completion.
// - Results held; reads never disturb order.
// - Status bits 5..0 read zero; flags read-only.
// - 32/16: quotient bytes 0..3, remainder 4..5.
// - 16/16 quotient 0..1, remainder 4..5; product 0..3.
`timescale 1ns/1ps
`include "mdv_defines.vh"
`default_nettype none

module mdv_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         calc_busy
);

    // ****************************************************************
    // Operation codes and order-tracking states.
    // ****************************************************************
    localparam OP_DIV32 = 2'h0;
    localparam OP_DIV16 = 2'h1;
    localparam OP_MUL   = 2'h2;

    localparam S_IDLE   = 4'h0;
    localparam S_W0     = 4'h1;
    localparam S_W01    = 4'h2;
    localparam S_W012   = 4'h3;
    localparam S_W0123  = 4'h4;
    localparam S_W01234 = 4'h5;
    localparam S_W014   = 4'h6;
    localparam S_W04    = 4'h7;
    localparam S_W041   = 4'h8;

    // ****************************************************************
    // Storage.
    // ****************************************************************
    reg  [7:0]  operand [0:5];
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [3:0]  seq;
    reg  [3:0]  next_seq;
    reg  [1:0]  op;
    reg  [1:0]  next_op;
    reg  [4:0]  lat_cnt;
    reg         access_error_flag;
    reg         overflow_flag;
    reg  [7:0]  rd_byte;
    reg         rd_hit;
    reg         start_calc;
    integer     i;

    wire        wr_fire;
    wire        wr_mapped;
    wire        wr_operand;
    wire [2:0]  wr_idx;
    wire        data_wr;
    wire        ar_fire;
    wire [2:0]  rd_idx;
    wire        rd_operand;
    wire        rd_status;
    wire        finish;
    wire [31:0] div_quo;
    wire [15:0] div_rem;
    wire [31:0] mul_prod;
    wire        access_now;
    wire        ovf_now;

    // ****************************************************************
    // Write address decode.
    // ****************************************************************
    // A write is carried out once address and data have both been taken.
    assign wr_fire    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_idx     = aw_addr[4:2];
    assign wr_mapped  = (aw_addr[7:5] == 3'h0) && (wr_idx != 3'h7);
    assign wr_operand = (aw_addr[7:5] == 3'h0) && (wr_idx <= 3'h5);
    assign data_wr    = wr_fire & wr_operand & w_strb[0];

    // ****************************************************************
    // Read address decode.
    // ****************************************************************
    assign ar_fire    = s_axi_arvalid & s_axi_arready;
    assign rd_idx     = s_axi_araddr[4:2];
    assign rd_operand = (s_axi_araddr[7:5] == 3'h0) && (rd_idx <= 3'h5);
    assign rd_status  = (s_axi_araddr[7:5] == 3'h0) && (rd_idx == 3'h6);

    // ****************************************************************
    // Arithmetic units.
    // ****************************************************************
    // The divider loads on the start edge and iterates for 16 or 8 cycles.
    mdv_divider u_divider (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (start_calc && (next_op != OP_MUL)),
        .wide      (next_op == OP_DIV32),
        .dividend  ({operand[3], operand[2], operand[1], operand[0]}),
        .divisor   ({w_data[7:0], operand[4]}),
        .quotient  (div_quo),
        .remainder (div_rem)
    );

    // The divisor high byte is the one being written in the start cycle.
    mdv_multiplier u_multiplier (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .start        (start_calc && (next_op == OP_MUL)),
        .multiplicand ({operand[1], operand[0]}),
        .multiplier   ({w_data[7:0], operand[4]}),
        .product      (mul_prod)
    );

    // ****************************************************************
    // Write-order tracking.
    // ****************************************************************
    // Only operand writes move the tracker, so other traffic may interleave.
    always @*
    begin
        next_seq   = seq;
        next_op    = op;
        start_calc = 1'b0;
        if (data_wr && !calc_busy)
        begin
            case (wr_idx)
                3'h0: next_seq = S_W0;
                3'h1:
                begin
                    if (seq == S_W0)
                        next_seq = S_W01;
                    else if (seq == S_W04)
                        next_seq = S_W041;
                    else
                        next_seq = S_IDLE;
                end
                3'h2: next_seq = (seq == S_W01) ? S_W012 : S_IDLE;
                3'h3: next_seq = (seq == S_W012) ? S_W0123 : S_IDLE;
                3'h4:
                begin
                    if (seq == S_W0123)
                        next_seq = S_W01234;
                    else if (seq == S_W01)
                        next_seq = S_W014;
                    else if (seq == S_W0)
                        next_seq = S_W04;
                    else
                        next_seq = S_IDLE;
                end
                3'h5:
                begin
                    next_seq = S_IDLE;
                    case (seq)
                        S_W01234:
                        begin
                            start_calc = 1'b1;
                            next_op    = OP_DIV32;
                        end
                        S_W014:
                        begin
                            start_calc = 1'b1;
                            next_op    = OP_DIV16;
                        end
                        S_W041:
                        begin
                            start_calc = 1'b1;
                            next_op    = OP_MUL;
                        end
                        default: start_calc = 1'b0;
                    endcase
                end
                default: next_seq = seq;
            endcase
        end
    end

    // ****************************************************************
    // Calculation timing.
    // ****************************************************************
    // The busy window lasts exactly the documented latency of each operation.
    assign finish = calc_busy && (lat_cnt == 5'h01);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seq       <= S_IDLE;
            op        <= OP_DIV32;
            calc_busy <= 1'b0;
            lat_cnt   <= 5'h00;
        end
        else
        begin
            seq <= next_seq;
            op  <= next_op;
            if (start_calc)
            begin
                calc_busy <= 1'b1;
                case (next_op)
                    OP_DIV16: lat_cnt <= `MDV_LAT_DIV16;
                    OP_MUL:   lat_cnt <= `MDV_LAT_MUL;
                    default:  lat_cnt <= `MDV_LAT_DIV32;
                endcase
            end
            else if (calc_busy)
            begin
                lat_cnt <= lat_cnt - 5'h01;
                if (finish)
                    calc_busy <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Operand and result storage.
    // ****************************************************************
    // Results replace operands on completion and stay until rewritten.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < 6; i = i + 1)
                operand[i] <= `MDV_OPERAND_RESET;
        end
        else if (finish)
        begin
            case (op)
                OP_MUL:
                begin
                    operand[0] <= mul_prod[7:0];
                    operand[1] <= mul_prod[15:8];
                    operand[2] <= mul_prod[23:16];
                    operand[3] <= mul_prod[31:24];
                end
                OP_DIV16:
                begin
                    operand[0] <= div_quo[7:0];
                    operand[1] <= div_quo[15:8];
                    operand[4] <= div_rem[7:0];
                    operand[5] <= div_rem[15:8];
                end
                default:
                begin
                    operand[0] <= div_quo[7:0];
                    operand[1] <= div_quo[15:8];
                    operand[2] <= div_quo[23:16];
                    operand[3] <= div_quo[31:24];
                    operand[4] <= div_rem[7:0];
                    operand[5] <= div_rem[15:8];
                end
            endcase
        end
        else if (data_wr && !calc_busy)
            operand[wr_idx] <= w_data[7:0];
    end

    // ****************************************************************
    // Status flags.
    // ****************************************************************
    // A data write during a calculation is refused and flagged; a data read is answered and flagged.
    assign access_now = calc_busy && ((wr_fire && wr_operand) || (ar_fire && rd_operand));

    // Overflow is judged from the product, or from the divisor, of the operation just finishing.
    assign ovf_now = (op == OP_MUL) ? (mul_prod[31:16] != 16'h0000)
                                    : ({operand[5], operand[4]} == 16'h0000);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            access_error_flag <= 1'b0;
            overflow_flag     <= 1'b0;
        end
        else
        begin
            // Setting wins over a clearing read in the same cycle.
            if (access_now)
                access_error_flag <= 1'b1;
            else if (ar_fire && rd_status && !calc_busy)
                access_error_flag <= 1'b0;
            if (finish)
                overflow_flag <= ovf_now;
        end
    end

    // ****************************************************************
    // Read data selection.
    // ****************************************************************
    // Reads have no side effect on operands or on the order tracker.
    always @*
    begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (rd_operand)
            rd_byte = operand[rd_idx];
        else if (rd_status)
        begin
            rd_byte = 8'h00;
            rd_byte[`MDV_STAT_ACCESS_ERROR_BIT] = access_error_flag;
            rd_byte[`MDV_STAT_OVERFLOW_BIT]     = overflow_flag;
        end
        else
            rd_hit = 1'b0;
    end

    // ****************************************************************
    // AXI4-Lite write channels.
    // ****************************************************************
    // Address and data are taken in either order; the response follows both.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MDV_RESP_OKAY;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                // The status register is read-only and ignores writes.
                s_axi_bresp  <= wr_mapped ? `MDV_RESP_OKAY : `MDV_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite read channels.
    // ****************************************************************
    // Data is presented the cycle after the address is taken.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MDV_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= rd_hit ? `MDV_RESP_OKAY : `MDV_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // mdv_top

`default_nettype wire

// ---- rtl/mdv_defines.vh ----
`ifndef MDV_DEFINES_VH
`define MDV_DEFINES_VH

// ****************************************************************
// Register byte addresses on the AXI4-Lite bus.
// ****************************************************************
`define MDV_ADDR_OPERAND_BYTE_0 8'h00
`define MDV_ADDR_OPERAND_BYTE_1 8'h04
`define MDV_ADDR_OPERAND_BYTE_2 8'h08
`define MDV_ADDR_OPERAND_BYTE_3 8'h0C
`define MDV_ADDR_OPERAND_BYTE_4 8'h10
`define MDV_ADDR_OPERAND_BYTE_5 8'h14
`define MDV_ADDR_MULDIV_STATUS  8'h18

// ****************************************************************
// Status register layout and reset values.
// ****************************************************************
`define MDV_STAT_ACCESS_ERROR_BIT 7
`define MDV_STAT_OVERFLOW_BIT     6
`define MDV_STAT_RESET            8'h00
`define MDV_OPERAND_RESET         8'h00

// ****************************************************************
// Calculation latencies in system clock periods.
// ****************************************************************
`define MDV_LAT_DIV32 5'h11
`define MDV_LAT_DIV16 5'h09
`define MDV_LAT_MUL   5'h0B

// Divider iteration counts, two quotient bits per cycle.
`define MDV_DIV_ITER32 5'h10
`define MDV_DIV_ITER16 5'h08

// ****************************************************************
// AXI response codes.
// ****************************************************************
`define MDV_RESP_OKAY   2'h0
`define MDV_RESP_SLVERR 2'h2

`endif

// ---- rtl/mdv_multiplier.v ----
`timescale 1ns/1ps
`default_nettype none

// Unsigned 16x16 multiplier with a registered product.
module mdv_multiplier (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        start,
    input  wire [15:0] multiplicand,
    input  wire [15:0] multiplier,
    output reg  [31:0] product
);

    // The product is captured on the start edge and held until the next start.
    always @(posedge aclk)
    begin
        if (!aresetn)
            product <= 32'h0000_0000;
        else if (start)
            product <= multiplicand * multiplier;
    end

endmodule // mdv_multiplier

`default_nettype wire

// ---- rtl/mdv_divider.v ----
`timescale 1ns/1ps
`include "mdv_defines.vh"
`default_nettype none

// Unsigned restoring divider, two quotient bits per clock.
module mdv_divider (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        start,
    input  wire        wide,
    input  wire [31:0] dividend,
    input  wire [15:0] divisor,
    output reg  [31:0] quotient,
    output reg  [15:0] remainder
);

    reg  [15:0] dvs;
    reg  [4:0]  iter;
    wire [47:0] step1;
    wire [47:0] step2;

    // One restoring step: shift in a dividend bit, subtract if it fits.
    function [47:0] mdv_step;
        input [15:0] r;
        input [31:0] q;
        input [15:0] d;
        reg   [16:0] t;
        reg          fit;
        begin
            t   = {r, q[31]};
            fit = (t >= {1'b0, d});
            if (fit)
                t = t - {1'b0, d};
            mdv_step = {t[15:0], q[30:0], fit};
        end
    endfunction

    assign step1 = mdv_step(remainder, quotient, dvs);
    assign step2 = mdv_step(step1[47:32], step1[31:0], dvs);

    // A short dividend sits in the upper half so that eight iterations finish it.
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            quotient  <= 32'h0000_0000;
            remainder <= 16'h0000;
            dvs       <= 16'h0000;
            iter      <= 5'h00;
        end
        else if (start)
        begin
            quotient  <= wide ? dividend : {dividend[15:0], 16'h0000};
            remainder <= 16'h0000;
            dvs       <= divisor;
            iter      <= wide ? `MDV_DIV_ITER32 : `MDV_DIV_ITER16;
        end
        else if (iter != 5'h00)
        begin
            quotient  <= step2[31:0];
            remainder <= step2[47:32];
            iter      <= iter - 5'h01;
        end
    end

endmodule // mdv_divider

`default_nettype wire

// ---- rtl/_unused_placeholder_none.v ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- testbench/mdv_top_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus and calculation properties.
// ****************
module mdv_top_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        calc_busy
);
    logic [7:0] last_ar;
    logic [4:0] busy_cnt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Keeps the address of the read under way and counts the cycles of a calculation.
    always @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            last_ar <= s_axi_araddr;
        busy_cnt <= (!aresetn || !calc_busy) ? 5'h00 : busy_cnt + 5'h01;
    end
    // The busy span must be one of the three calculation lengths.
    a_busy_length: assert property ($fell(calc_busy) |->
        busy_cnt == 5'h11 || busy_cnt == 5'h09 || busy_cnt == 5'h0B)
        else $error("calculation length wrong");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_status_low: assert property (s_axi_rvalid && last_ar == 8'h18 |-> s_axi_rdata[5:0] == 6'h00)
        else $error("status low bits set");
    a_unmapped_read: assert property (s_axi_rvalid && last_ar >= 8'h1C |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
endmodule // mdv_top_properties

bind mdv_top mdv_top_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .calc_busy(calc_busy));
`default_nettype wire

// ---- testbench/multiply_divide_unit_tb.sv ----
`timescale 1ns/1ps
`include "mdv_defines.vh"
`default_nettype none
module multiply_divide_unit_tb;
    // ****************
    // Signals, operation table and bus tasks.
    // ****************
    typedef struct packed {logic [1:0] op; logic [31:0] a; logic [15:0] b;
        logic [31:0] lo; logic [15:0] hi; logic ov;} mdv_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, busy;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          miscompares = 0;
    int          compares = 0;
    int          n;
    logic [7:0]  d;
    logic [1:0]  rs;
    logic [31:0] lo;
    logic [15:0] hi;
    logic [3:0]  ix;
    mdv_row_t    r;
    // Write order, read order and length of the three operations.
    logic [23:0] wseq [3] = '{24'h012345, 24'h014500, 24'h041500};
    logic [23:0] rseq [3] = '{24'h012345, 24'h014500, 24'h012300};
    logic [4:0]  lat [3] = '{`MDV_LAT_DIV32, `MDV_LAT_DIV16, `MDV_LAT_MUL};
    // Operation, operands, low result, remainder and overflow; each overflow row is followed by a clean row to catch a stale flag.
    mdv_row_t    rows [8] = '{'{2'h0, 32'h00FFFFFF, 16'h0010, 32'h000FFFFF, 16'h000F, 1'b0},
                              '{2'h0, 32'hFFFFFFFF, 16'hFFFF, 32'h00010001, 16'h0000, 1'b0},
                              '{2'h0, 32'h00000005, 16'h0000, 32'h00000000, 16'h0000, 1'b1},
                              '{2'h1, 32'h00001234, 16'h0010, 32'h00000123, 16'h0004, 1'b0},
                              '{2'h1, 32'h0000FFFF, 16'h0000, 32'h00000000, 16'h0000, 1'b1},
                              '{2'h2, 32'h000000FF, 16'h00FF, 32'h0000FE01, 16'h0000, 1'b0},
                              '{2'h2, 32'h0000FFFF, 16'hFFFF, 32'hFFFE0001, 16'h0000, 1'b1},
                              '{2'h1, 32'h0000FFFF, 16'h0001, 32'h0000FFFF, 16'h0000, 1'b0}};

    always #12.5 aclk = ~aclk;

    mdv_top dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .calc_busy(busy));

    // Compares one value and counts it.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One write; bready stands from the start, so the response is taken at once.
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid && bready)
                break;
        end
        rs = bresp;
        bready <= 1'b0;
    endtask

    // One read; rready rises once the data stands, so the data must hold.
    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid && rready)
                break;
            if (rvalid)
                rready <= 1'b1;
        end
        d = rdata[7:0];
        rready <= 1'b0;
    endtask

    // Counts the falling edges at which the calculation is still busy.
    task wait_done;
        n = 0;
        @(negedge aclk);
        while (busy === 1'b1 && n < 40)
        begin
            n++;
            @(negedge aclk);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial
    begin
        #500000;
        miscompares++;
        close_out;
    end

    // Reset, the operation table, then the awkward cases.
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h18);
        chk("status reset", 32'h0, {24'h0, d});
        $display("reset test done");
        for (int k = 0; k < 8; k++)
        begin
            r = rows[k];
            for (int j = 0; j < (r.op == 2'h0 ? 6 : 4); j++)
            begin
                ix = wseq[r.op][23 - 4 * j -: 4];
                wr({2'h0, ix, 2'h0}, ix < 4 ? r.a[8 * ix +: 8] : r.b[8 * (ix - 4) +: 8]);
            end
            wait_done;
            chk("busy cycles", {27'h0, lat[r.op]} - 32'h1, n);
            rd(8'h18);
            chk("status", {24'h0, 1'b0, r.ov, 6'h00}, {24'h0, d});
            lo = 32'h0;
            hi = 16'h0;
            for (int j = 0; j < (r.op == 2'h0 ? 6 : 4) && (r.op == 2'h2 || !r.ov); j++)
            begin
                ix = rseq[r.op][23 - 4 * j -: 4];
                rd({2'h0, ix, 2'h0});
                if (ix < 4)
                    lo[8 * ix +: 8] = d;
                else
                    hi[8 * (ix - 4) +: 8] = d;
            end
            chk("result", r.lo, lo);
            chk("remainder", {16'h0, r.hi}, {16'h0, hi});
            $display("row %0d done", k);
        end
        wr(8'h00, 8'h02);
        wr(8'h10, 8'h03);
        wr(8'h04, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h00, 8'h55);
        rd(8'h04);
        wait_done;
        rd(8'h18);
        chk("error flag", 32'h80, {24'h0, d});
        rd(8'h18);
        chk("error clear", 32'h0, {24'h0, d});
        rd(8'h00);
        chk("refused write", 32'h06, {24'h0, d});
        $display("busy access test done");
        wr(8'h00, 8'h08);
        wr(8'h04, 8'h00);
        wr(8'h08, 8'hFF);
        wr(8'h14, 8'h00);
        chk("no start", 32'h0, {31'h0, busy});
        wr(8'h00, 8'h08);
        wr(8'h04, 8'h00);
        wr(8'h18, 8'hFF);
        wr(8'h1C, 8'h01);
        chk("unmapped write", 32'h2, {30'h0, rs});
        rd(8'h18);
        wr(8'h10, 8'h02);
        wr(8'h14, 8'h00);
        wait_done;
        chk("busy cycles", 32'h8, n);
        rd(8'h18);
        chk("status read-only", 32'h0, {24'h0, d});
        rd(8'h00);
        chk("quotient", 32'h04, {24'h0, d});
        rd(8'h1C);
        $display("order test done");
        close_out;
    end
endmodule // multiply_divide_unit_tb
`default_nettype wire
